// ---- bench/rctr_regs_assertions.sv ----
// assertions on the rms config and trigger register bank ports
`timescale 1ns/10ps
`default_nettype none
module rctr_regs_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [15:0] rms_result_in,
  input wire logic rms_done_in,
  input wire logic [7:0] alert_flags_in,
  input wire logic [3:0] rms_channel_select_out,
  input wire logic [1:0] window_length_code_out,
  input wire logic [16:0] window_samples_out,
  input wire logic [4:0] output_trigger_out,
  input wire logic [4:0] output_event_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  read_valid_a: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read valid late");
  cfg_fields_a: assert property (reg_wr_in && reg_addr_in == 8'hC0 |=>
    rms_channel_select_out == $past(reg_wdata_in[7:4])
    && window_length_code_out == $past(reg_wdata_in[1:0]))
    else $error("config fields wrong");
  window_len_a: assert property (window_samples_out ==
    (17'h00400 << {window_length_code_out, 1'b0}))
    else $error("window length wrong");
  rsvd_zero_a: assert property (reg_rd_in && reg_addr_in == 8'hC0
    |=> !reg_rdata_out[3]) else $error("reserved bit set");
  cfg_back_a: assert property (reg_wr_in && reg_addr_in == 8'hC0 ##2
    (reg_rd_in && !reg_wr_in && reg_addr_in == 8'hC0)
    |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'hF7))
    else $error("config readback wrong");
  result_low_a: assert property (rms_done_in ##1 !rms_done_in ##1
    (!rms_done_in && reg_rd_in && reg_addr_in == 8'hC1)
    |=> reg_rdata_out == $past(rms_result_in[7:0], 3))
    else $error("result low byte wrong");
  idle_trig_a: assert property (alert_flags_in == 8'h00
    |=> output_trigger_out == 5'h00) else $error("trigger without alert");
  event_rise_a: assert property (output_event_out ==
    (output_trigger_out & ~$past(output_trigger_out)))
    else $error("event not on trigger rise");
endmodule // rctr_regs_chk
bind rctr_regs rctr_regs_chk i_rctr_regs_chk (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .rms_result_in(rms_result_in),
  .rms_done_in(rms_done_in), .alert_flags_in(alert_flags_in),
  .rms_channel_select_out(rms_channel_select_out),
  .window_length_code_out(window_length_code_out),
  .window_samples_out(window_samples_out),
  .output_trigger_out(output_trigger_out),
  .output_event_out(output_event_out));
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the rms config and trigger register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] res = 16'h0000;
  logic done = 1'b0;
  logic [7:0] alert = 8'h00;
  logic [7:0] v;
  wire [7:0] rdata;
  wire [3:0] chan;
  wire dc;
  wire [1:0] code;
  wire [16:0] samples;
  wire [4:0] trig;
  wire [4:0] evt;
  wire rvalid;
  wire err;
  wire chg;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // write flag nibble, address, data, expected readback
  logic [27:0] rows [0:18] = '{28'h0C00000, 28'h0C10000, 28'h0C20000,
    28'h0C30002, 28'h0C50001, 28'h0C70008, 28'h0C90004, 28'h0CB0020,
    28'h1C0FFF7, 28'h1C00800, 28'h1C3A5A5, 28'h1C55A5A, 28'h1C7FFFF,
    28'h1C98181, 28'h1CB0000, 28'h1C1FF00, 28'h1C2FF00, 28'h1C45500,
    28'h1C00000};
  rctr_regs i_rctr_regs (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .reg_err_out(err), .rms_result_in(res), .rms_done_in(done),
    .alert_flags_in(alert), .rms_channel_select_out(chan),
    .dc_removal_enable_out(dc), .window_length_code_out(code),
    .window_samples_out(samples), .root_mean_square_config_changed_out(chg),
    .output_trigger_out(trig), .output_event_out(evt));
  always #50 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [16:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr8(input logic [7:0] a, d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a);
    @(negedge clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    v = rdata;
  endtask
  task automatic conclude;
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // generous ceiling; the sequence needs about 110 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    chk("reset_cfg", {chan, dc, code}, 7'h00);
    chk("reset_win", samples, 17'h00400);
    chk("reset_trig", {evt, trig}, 10'h000);
    foreach (rows[i]) begin
      if (rows[i][24]) wr8(rows[i][23:16], rows[i][15:8]);
      rd8(rows[i][23:16]);
      chk("readback", v, rows[i][7:0]);
    end
    for (int k = 0; k < 4; k++) begin
      wr8(8'hC0, {k[3:0], 2'b01, k[1:0]});
      chk("cfg_changed", chg, 1'b1);
      chk("window", samples, 17'h00400 << (2 * k));
      chk("cfg", {chan, dc, code}, {k[3:0], 1'b1, k[1:0]});
    end
    wr8(8'hC1, 8'h11);
    chk("err_ro_write", err, 1'b1);
    chk("cfg_idle", chg, 1'b0);
    rd8(8'hC4);
    chk("err_unmapped", {err, rvalid, v}, 10'h300);
    @(negedge clk_in);
    res = 16'hABCD;
    done = 1'b1;
    @(negedge clk_in);
    done = 1'b0;
    rd8(8'hC1);
    chk("result_low", v, 8'hCD);
    chk("read_ok", {err, rvalid}, 2'h1);
    rd8(8'hC2);
    chk("result_high", v, 8'hAB);
    // second reset in mid-run must restore defaults
    @(negedge clk_in);
    rst_b_in = 1'b0;
    @(negedge clk_in);
    rst_b_in = 1'b1;
    chk("reset2_cfg", {chan, dc, code}, 7'h00);
    rd8(8'hC3);
    chk("mask0_reset", v, 8'h02);
    rd8(8'hC2);
    chk("high_reset", v, 8'h00);
    alert = 8'h02;
    @(negedge clk_in);
    chk("trig_rise", {evt, trig}, 10'h021);
    @(negedge clk_in);
    chk("trig_hold", {evt, trig}, 10'h001);
    alert = 8'h2D;
    @(negedge clk_in);
    chk("trig_multi", {evt, trig}, 10'h3DE);
    alert = 8'h00;
    wr8(8'hC3, 8'hFD);
    alert = 8'h02;
    @(negedge clk_in);
    chk("trig_masked", trig, 5'h00);
    alert = 8'h80;
    @(negedge clk_in);
    chk("trig_new_ch", trig, 5'h01);
    conclude();
  end
endmodule // tb_top
`default_nettype wire

// ---- design/rctr_consts.vh ----
// constants for the rms configuration and output trigger register bank
`ifndef RCTR_CONSTS_VH
`define RCTR_CONSTS_VH

`define RCTR_ADDR_W 8
`define RCTR_DATA_W 8
`define RCTR_NUM_CH 8
`define RCTR_NUM_OUT 5

`define RCTR_OFS_ROOT_MEAN_SQUARE_CONFIG 8'hC0
`define RCTR_OFS_RMS_LOW 8'hC1
`define RCTR_OFS_RMS_HIGH 8'hC2
`define RCTR_OFS_OUT0_MASK 8'hC3
`define RCTR_OFS_OUT1_MASK 8'hC5
`define RCTR_OFS_OUT2_MASK 8'hC7
`define RCTR_OFS_OUT3_MASK 8'hC9
`define RCTR_OFS_OUT4_MASK 8'hCB

`define RCTR_RST_ROOT_MEAN_SQUARE_CONFIG 8'h00
`define RCTR_RST_RMS_RESULT 16'h0000
`define RCTR_RST_OUT0_MASK 8'h02
`define RCTR_RST_OUT1_MASK 8'h01
`define RCTR_RST_OUT2_MASK 8'h08
`define RCTR_RST_OUT3_MASK 8'h04
`define RCTR_RST_OUT4_MASK 8'h20

`define RCTR_CFG_CHAN_HI 7
`define RCTR_CFG_CHAN_LO 4
`define RCTR_CFG_RSVD_BIT 3
`define RCTR_CFG_DC_BIT 2
`define RCTR_CFG_LEN_HI 1
`define RCTR_CFG_LEN_LO 0

`define RCTR_WIN_W 17
`define RCTR_WIN_1K 17'h00400
`define RCTR_WIN_4K 17'h01000
`define RCTR_WIN_16K 17'h04000
`define RCTR_WIN_64K 17'h10000

`endif

// ---- design/rctr_regs.v ----
// rms configuration, rms result and output trigger mask register bank
`timescale 1ns/10ps
`default_nettype none
`include "rctr_consts.vh"
module rctr_regs (
  input wire clk_in,
  input wire rst_b_in,
  input wire [`RCTR_ADDR_W-1:0] reg_addr_in,
  input wire [`RCTR_DATA_W-1:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [`RCTR_DATA_W-1:0] reg_rdata_out,
  output reg reg_rvalid_out,
  output reg reg_err_out,
  input wire [15:0] rms_result_in,
  input wire rms_done_in,
  input wire [`RCTR_NUM_CH-1:0] alert_flags_in,
  output reg [3:0] rms_channel_select_out,
  output reg dc_removal_enable_out,
  output reg [1:0] window_length_code_out,
  output reg [`RCTR_WIN_W-1:0] window_samples_out,
  output reg root_mean_square_config_changed_out,
  output wire [`RCTR_NUM_OUT-1:0] output_trigger_out,
  output wire [`RCTR_NUM_OUT-1:0] output_event_out
);

  // decode of the window code into a sample count
  function [`RCTR_WIN_W-1:0] win_samples;
    input [1:0] code;
    begin
      case (code)
        2'h0: win_samples = `RCTR_WIN_1K;
        2'h1: win_samples = `RCTR_WIN_4K;
        2'h2: win_samples = `RCTR_WIN_16K;
        default: win_samples = `RCTR_WIN_64K;
      endcase
    end
  endfunction

  // index of an output mask register, or 3'h7 if the address is not one
  function [2:0] mask_index;
    input [`RCTR_ADDR_W-1:0] addr;
    begin
      case (addr)
        `RCTR_OFS_OUT0_MASK: mask_index = 3'h0;
        `RCTR_OFS_OUT1_MASK: mask_index = 3'h1;
        `RCTR_OFS_OUT2_MASK: mask_index = 3'h2;
        `RCTR_OFS_OUT3_MASK: mask_index = 3'h3;
        `RCTR_OFS_OUT4_MASK: mask_index = 3'h4;
        default: mask_index = 3'h7;
      endcase
    end
  endfunction

  // configuration fields
  reg [3:0] chan_q;
  reg [3:0] chan_d;
  reg dc_en_q;
  reg dc_en_d;
  reg [1:0] win_code_q;
  reg [1:0] win_code_d;

  // result held as one word, loaded whole; the two bytes are read separately, so a done between the reads mixes two computations
  reg [15:0] result_q;
  reg [15:0] result_d;

  // output trigger masks, one register per output
  reg [`RCTR_DATA_W-1:0] mask0_q;
  reg [`RCTR_DATA_W-1:0] mask1_q;
  reg [`RCTR_DATA_W-1:0] mask2_q;
  reg [`RCTR_DATA_W-1:0] mask3_q;
  reg [`RCTR_DATA_W-1:0] mask4_q;
  wire [`RCTR_NUM_OUT-1:0] mask_we;
  wire [`RCTR_DATA_W-1:0] cfg_rst;

  wire [2:0] wr_mask_idx;
  wire [2:0] rd_mask_idx;
  wire wr_cfg;
  wire wr_mask;
  wire rd_mapped;
  wire wr_mapped;
  wire [`RCTR_DATA_W-1:0] cfg_view;
  reg [`RCTR_DATA_W-1:0] rdata_d;
  reg err_d;

  assign wr_mask_idx = mask_index(reg_addr_in);
  assign rd_mask_idx = wr_mask_idx;
  assign wr_cfg = reg_wr_in & (reg_addr_in == `RCTR_OFS_ROOT_MEAN_SQUARE_CONFIG);
  assign wr_mask = reg_wr_in & (wr_mask_idx != 3'h7);
  // one write enable per mask register
  assign mask_we[0] = wr_mask & (wr_mask_idx == 3'h0);
  assign mask_we[1] = wr_mask & (wr_mask_idx == 3'h1);
  assign mask_we[2] = wr_mask & (wr_mask_idx == 3'h2);
  assign mask_we[3] = wr_mask & (wr_mask_idx == 3'h3);
  assign mask_we[4] = wr_mask & (wr_mask_idx == 3'h4);
  // reset image of the configuration byte, split into its fields
  assign cfg_rst = `RCTR_RST_ROOT_MEAN_SQUARE_CONFIG;

  // result bytes are mapped for reads only; writes to them are refused
  assign rd_mapped = (reg_addr_in == `RCTR_OFS_ROOT_MEAN_SQUARE_CONFIG) |
                     (reg_addr_in == `RCTR_OFS_RMS_LOW) |
                     (reg_addr_in == `RCTR_OFS_RMS_HIGH) |
                     (rd_mask_idx != 3'h7);
  assign wr_mapped = (reg_addr_in == `RCTR_OFS_ROOT_MEAN_SQUARE_CONFIG) |
                     (wr_mask_idx != 3'h7);

  // reserved bit is a hard zero, no storage behind it
  assign cfg_view = {chan_q, 1'b0, dc_en_q, win_code_q};

  // configuration next state, one field at a time
  always @* begin
    chan_d = chan_q;
    if (wr_cfg) begin
      chan_d = reg_wdata_in[`RCTR_CFG_CHAN_HI:`RCTR_CFG_CHAN_LO];
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      chan_q <= cfg_rst[`RCTR_CFG_CHAN_HI:`RCTR_CFG_CHAN_LO];
    end else begin
      chan_q <= chan_d;
    end
  end

  always @* begin
    dc_en_d = dc_en_q;
    if (wr_cfg) begin
      dc_en_d = reg_wdata_in[`RCTR_CFG_DC_BIT];
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      dc_en_q <= cfg_rst[`RCTR_CFG_DC_BIT];
    end else begin
      dc_en_q <= dc_en_d;
    end
  end

  always @* begin
    win_code_d = win_code_q;
    if (wr_cfg) begin
      win_code_d = reg_wdata_in[`RCTR_CFG_LEN_HI:`RCTR_CFG_LEN_LO];
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      win_code_q <= cfg_rst[`RCTR_CFG_LEN_HI:`RCTR_CFG_LEN_LO];
    end else begin
      win_code_q <= win_code_d;
    end
  end

  // result capture: one 16-bit load, never byte by byte
  always @* begin
    result_d = result_q;
    if (rms_done_in) begin
      result_d = rms_result_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      result_q <= `RCTR_RST_RMS_RESULT;
    end else begin
      result_q <= result_d;
    end
  end

  // one register per mask, each with its own reset value
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      mask0_q <= `RCTR_RST_OUT0_MASK;
    end else if (mask_we[0]) begin
      mask0_q <= reg_wdata_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      mask1_q <= `RCTR_RST_OUT1_MASK;
    end else if (mask_we[1]) begin
      mask1_q <= reg_wdata_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      mask2_q <= `RCTR_RST_OUT2_MASK;
    end else if (mask_we[2]) begin
      mask2_q <= reg_wdata_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      mask3_q <= `RCTR_RST_OUT3_MASK;
    end else if (mask_we[3]) begin
      mask3_q <= reg_wdata_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      mask4_q <= `RCTR_RST_OUT4_MASK;
    end else if (mask_we[4]) begin
      mask4_q <= reg_wdata_in;
    end
  end

  // read mux; a write and a read in one cycle return the old value
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_in)
      `RCTR_OFS_ROOT_MEAN_SQUARE_CONFIG: rdata_d = cfg_view;
      `RCTR_OFS_RMS_LOW: rdata_d = result_q[7:0];
      `RCTR_OFS_RMS_HIGH: rdata_d = result_q[15:8];
      `RCTR_OFS_OUT0_MASK: rdata_d = mask0_q;
      `RCTR_OFS_OUT1_MASK: rdata_d = mask1_q;
      `RCTR_OFS_OUT2_MASK: rdata_d = mask2_q;
      `RCTR_OFS_OUT3_MASK: rdata_d = mask3_q;
      `RCTR_OFS_OUT4_MASK: rdata_d = mask4_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // error on unmapped read, or on a write to an unmapped or read-only byte
  always @* begin
    err_d = 1'b0;
    if (reg_rd_in & ~rd_mapped) begin
      err_d = 1'b1;
    end
    if (reg_wr_in & ~wr_mapped) begin
      err_d = 1'b1;
    end
  end

  // data only moves on a read so a stale answer stays put
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mapped ? rdata_d : 8'h00;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      reg_rvalid_out <= 1'b0;
      reg_err_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      reg_err_out <= err_d;
    end
  end

  // configuration fields driven to the rms engine from next state
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      rms_channel_select_out <= cfg_rst[`RCTR_CFG_CHAN_HI:`RCTR_CFG_CHAN_LO];
    end else begin
      rms_channel_select_out <= chan_d;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      dc_removal_enable_out <= cfg_rst[`RCTR_CFG_DC_BIT];
    end else begin
      dc_removal_enable_out <= dc_en_d;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      window_length_code_out <= cfg_rst[`RCTR_CFG_LEN_HI:`RCTR_CFG_LEN_LO];
    end else begin
      window_length_code_out <= win_code_d;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      window_samples_out <= `RCTR_WIN_1K;
    end else begin
      window_samples_out <= win_samples(win_code_d);
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      root_mean_square_config_changed_out <= 1'b0;
    end else begin
      // a write to the configuration byte restarts the window; a half-old window would be garbage
      root_mean_square_config_changed_out <= wr_cfg;
    end
  end

  // one trigger lane per output
  rctr_trig_lane u_lane0 (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mask_in(mask0_q),
    .alert_in(alert_flags_in),
    .level_out(output_trigger_out[0]),
    .event_out(output_event_out[0])
  );

  rctr_trig_lane u_lane1 (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mask_in(mask1_q),
    .alert_in(alert_flags_in),
    .level_out(output_trigger_out[1]),
    .event_out(output_event_out[1])
  );

  rctr_trig_lane u_lane2 (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mask_in(mask2_q),
    .alert_in(alert_flags_in),
    .level_out(output_trigger_out[2]),
    .event_out(output_event_out[2])
  );

  rctr_trig_lane u_lane3 (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mask_in(mask3_q),
    .alert_in(alert_flags_in),
    .level_out(output_trigger_out[3]),
    .event_out(output_event_out[3])
  );

  rctr_trig_lane u_lane4 (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .mask_in(mask4_q),
    .alert_in(alert_flags_in),
    .level_out(output_trigger_out[4]),
    .event_out(output_event_out[4])
  );

endmodule // rctr_regs
`default_nettype wire

// ---- design/rctr_trig_lane.v ----
// one output trigger lane: masked or of channel alerts with event pulse
`timescale 1ns/10ps
`default_nettype none
`include "rctr_consts.vh"
module rctr_trig_lane (
  input wire clk_in,
  input wire rst_b_in,
  input wire [`RCTR_NUM_CH-1:0] mask_in,
  input wire [`RCTR_NUM_CH-1:0] alert_in,
  output reg level_out,
  output reg event_out
);
  wire any_d;

  assign any_d = |(mask_in & alert_in);

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      level_out <= 1'b0;
      event_out <= 1'b0;
    end else begin
      level_out <= any_d;
      // one pulse per rising edge, so a held alert updates the output once
      event_out <= any_d & ~level_out;
    end
  end
endmodule // rctr_trig_lane
`default_nettype wire
